// file: hdl/dbu_pkg.sv
// dbu_pkg: constants for the debug unit front end.
// assumes a 32-bit core with coprocessor access decoded upstream.
package dbu_pkg;
  localparam logic [3:0] SYS_CP_NUM     = 4'hF;
  localparam logic [3:0] DBG_CP_NUM     = 4'hE;
  localparam logic [3:0] SYS_DBG_PRI    = 4'hE;
  localparam logic [3:0] SEC_IBRK0      = 4'h8;
  localparam logic [3:0] SEC_IBRK1      = 4'h9;
  localparam logic [3:0] SEC_DBRK0      = 4'h0;
  localparam logic [3:0] SEC_DBRK1      = 4'h3;
  localparam logic [3:0] SEC_DBCTL      = 4'h4;
  localparam logic [3:0] PRI_TX         = 4'h8;
  localparam logic [3:0] PRI_RX         = 4'h9;
  localparam logic [3:0] PRI_DCS        = 4'hA;
  localparam logic [3:0] PRI_TBUF       = 4'hB;
  localparam logic [3:0] PRI_CHK0       = 4'hC;
  localparam logic [3:0] PRI_CHK1       = 4'hD;
  localparam logic [3:0] PRI_HSK        = 4'hE;
  localparam logic [4:0] MODE_USER      = 5'h10;
  localparam logic [4:0] MODE_ABORT     = 5'h17;
  localparam logic [4:0] MODE_DEBUG     = 5'h15;
  localparam logic [31:0] VEC_RESET     = 32'h0000_0000;
  localparam logic [31:0] VEC_PABT      = 32'h0000_000C;
  localparam logic [31:0] VEC_DABT      = 32'h0000_0010;
  localparam int DCS_GE_BIT   = 31;
  localparam int DCS_HALT_BIT = 30;
  localparam int DCS_TE_BIT   = 0;
  localparam int HSK_RXF_BIT  = 31;
  localparam int HSK_TXF_BIT  = 28;
  localparam logic [31:0] DCS_RESET     = 32'h0000_0000;
  localparam logic [31:0] DCS_JTAG_MASK = 32'h4000_00FF;
  typedef enum logic [2:0] {
    DBU_IDLE  = 3'b001,
    DBU_HALT  = 3'b010,
    DBU_MON   = 3'b100
  } dbu_state_t;
endpackage : dbu_pkg

// file: hdl/dbu_reg.sv
// dbu_reg: one 32-bit register with core and debugger write ports.
// assumes both writers on ref_clk; the debugger write wins a collision.
`timescale 1ns/1ps
module dbu_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        core_we,
  input  wire logic [31:0] core_wdata,
  input  wire logic        jtag_we,
  input  wire logic [31:0] jtag_wdata,
  output logic      [31:0] q
);
  logic [31:0] next_q;
  always_comb begin
    next_q = q;
    if (core_we) begin
      next_q = core_wdata;
    end
    if (jtag_we) begin
      next_q = jtag_wdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= RESET_VAL;
    end else begin
      q <= next_q;
    end
  end
endmodule : dbu_reg

// file: hdl/dbu_top.sv
// dbu_top: debug unit coprocessor decode, privilege check and exception dispatch.
// assumes the core presents one coprocessor access per cycle and a debug cause strobe.
// Functional notes
// - system coprocessor primary 14 decodes secondary 8,9,0,3,4 to breakpoint registers.
// - debug coprocessor primaries 8 to 14 map to link, control, trace registers.
// - reads, writes, loads, stores accepted; debug coprocessor data operations trap undefined.
// - debug coprocessor registers chosen by primary index alone.
// - user mode debug register access traps undefined instead of completing.
// - debugger reaches transmit, receive and selected control bits over JTAG.
// - debugger can halt, redirect, inspect and resume execution.
// - unit works in exactly one of halt or monitor mode.
// - halt mode uses the reset vector as debug entry.
// - debug processor mode is code 0x15 in status mode bits.
// - halt mode exception enters debug mode through reset vector.
// - handler can be downloaded over JTAG and locked in instruction cache.
// - monitor mode exceptions become prefetch or data aborts by cause.
// - monitor mode enters abort mode via prefetch or data abort vector.
// - global debug enable clears on reset, reset vector trap stays live.
// - a single halt bit selects halt or monitor mode.
`timescale 1ns/1ps
module dbu_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cp_valid,
  input  wire logic [3:0]  cp_num,
  input  wire logic        cp_write,
  input  wire logic        cp_dataop,
  input  wire logic [3:0]  primary_index_field,
  input  wire logic [3:0]  secondary_index_field,
  input  wire logic [31:0] cp_wdata,
  input  wire logic [4:0]  current_mode,
  input  wire logic        jtag_we,
  input  wire logic [2:0]  jtag_sel,
  input  wire logic [31:0] jtag_wdata,
  input  wire logic        dbg_event,
  input  wire logic        dbg_event_data,
  input  wire logic        reset_trap,
  input  wire logic        core_resume,
  output logic      [31:0] cp_rdata,
  output logic             cp_undef,
  output logic      [31:0] jtag_rdata,
  output logic             exc_take,
  output logic      [31:0] exc_vector,
  output logic      [4:0]  exc_mode,
  output logic             core_halted,
  output logic             trace_enable,
  output logic      [31:0] ibrk_addr0,
  output logic      [31:0] ibrk_addr1,
  output logic      [31:0] dbrk_addr0,
  output logic      [31:0] dbrk_addr1,
  output logic      [31:0] dbrk_ctrl
);
  import dbu_pkg::*;

  localparam int NREG = 12;
  localparam int IDX_TX = 5;
  localparam int IDX_RX = 6;
  localparam int IDX_DCS = 7;
  localparam int IDX_HSK = 11;

  logic [NREG-1:0]  core_we;
  logic [NREG-1:0]  jt_we;
  logic [31:0]      jt_data [NREG];
  logic [31:0]      regq    [NREG];
  logic             is_sys;
  logic             is_dbg;
  logic             priv_ok;
  logic [3:0]       sel;
  logic             sel_ok;
  logic [31:0]      dcs;
  logic             ge;
  logic             halt_mode;
  dbu_state_t       state;
  dbu_state_t       next_state;
  logic             next_exc_take;
  logic [31:0]      next_exc_vector;
  logic [4:0]       next_exc_mode;
  logic [31:0]      next_cp_rdata;
  logic             next_cp_undef;
  logic             dcs_auto_we;
  logic             accept;

  assign is_sys  = cp_valid && (cp_num == SYS_CP_NUM) && (primary_index_field == SYS_DBG_PRI);
  assign is_dbg  = cp_valid && (cp_num == DBG_CP_NUM);
  assign priv_ok = (current_mode != MODE_USER);
  assign dcs       = regq[IDX_DCS];
  assign ge        = dcs[DCS_GE_BIT];
  assign halt_mode = dcs[DCS_HALT_BIT];
  assign accept    = dbg_event && (ge || reset_trap);

  // register selection: index 0..4 breakpoints, 5..11 debug coprocessor
  always_comb begin
    sel    = 4'hF;
    sel_ok = 1'b0;
    if (is_sys) begin
      sel_ok = 1'b1;
      case (secondary_index_field)
        SEC_IBRK0: sel = 4'h0;
        SEC_IBRK1: sel = 4'h1;
        SEC_DBRK0: sel = 4'h2;
        SEC_DBRK1: sel = 4'h3;
        SEC_DBCTL: sel = 4'h4;
        default:   sel_ok = 1'b0;
      endcase
    end else if (is_dbg && !cp_dataop) begin
      sel_ok = (primary_index_field >= PRI_TX) && (primary_index_field <= PRI_HSK);
      sel    = primary_index_field - PRI_TX + 4'h5;
    end
  end

  // auto clear of trace enable on a taken debug exception
  assign dcs_auto_we = exc_take;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      logic [31:0] cw;
      always_comb begin
        core_we[g] = sel_ok && priv_ok && cp_write && (sel == 4'(g));
        cw         = cp_wdata;
        // hardware clear of trace enable survives a same-cycle core write
        if (g == IDX_DCS && dcs_auto_we) begin
          cw         = (core_we[g] ? cp_wdata : regq[g]) & ~(32'h1 << DCS_TE_BIT);
          core_we[g] = 1'b1;
        end
        jt_we[g]   = 1'b0;
        jt_data[g] = jtag_wdata;
        if (jtag_we) begin
          if (g == IDX_TX && jtag_sel == 3'h0) jt_we[g] = 1'b1;
          if (g == IDX_RX && jtag_sel == 3'h1) jt_we[g] = 1'b1;
          if (g == IDX_DCS && jtag_sel == 3'h2) begin
            jt_we[g]   = 1'b1;
            jt_data[g] = (regq[g] & ~DCS_JTAG_MASK) | (jtag_wdata & DCS_JTAG_MASK);
          end
          if (g == IDX_HSK && jtag_sel == 3'h3) jt_we[g] = 1'b1;
        end
      end
      dbu_reg #(
        .RESET_VAL (DCS_RESET)
      ) u_reg (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .core_we    (core_we[g]),
        .core_wdata (cw),
        .jtag_we    (jt_we[g]),
        .jtag_wdata (jt_data[g]),
        .q          (regq[g])
      );
    end
  endgenerate

  assign ibrk_addr0   = regq[0];
  assign ibrk_addr1   = regq[1];
  assign dbrk_addr0   = regq[2];
  assign dbrk_addr1   = regq[3];
  assign dbrk_ctrl    = regq[4];
  assign trace_enable = dcs[DCS_TE_BIT] && ge;
  assign core_halted  = (state == DBU_HALT);

  always_comb begin
    case (jtag_sel)
      3'h0:    jtag_rdata = regq[IDX_TX];
      3'h1:    jtag_rdata = regq[IDX_RX];
      3'h2:    jtag_rdata = dcs & DCS_JTAG_MASK;
      3'h3:    jtag_rdata = regq[IDX_HSK];
      default: jtag_rdata = 32'h0000_0000;
    endcase
  end

  // read data and undefined trap
  always_comb begin
    next_cp_undef = 1'b0;
    next_cp_rdata = cp_rdata;
    if (is_dbg && cp_dataop) begin
      next_cp_undef = 1'b1;
    end else if ((is_sys || is_dbg) && !priv_ok) begin
      next_cp_undef = 1'b1;
    end else if (sel_ok && !cp_write) begin
      next_cp_rdata = regq[sel];
    end
  end

  // exception dispatch
  always_comb begin
    next_state      = state;
    next_exc_take   = 1'b0;
    next_exc_vector = exc_vector;
    next_exc_mode   = exc_mode;
    case (state)
      DBU_IDLE, DBU_MON: begin
        if (state == DBU_MON && core_resume) begin
          next_state = DBU_IDLE;
        end else if (accept && state == DBU_IDLE) begin
          next_exc_take = 1'b1;
          if (halt_mode || (reset_trap && !ge)) begin
            next_state      = DBU_HALT;
            next_exc_vector = VEC_RESET;
            next_exc_mode   = MODE_DEBUG;
          end else begin
            next_state      = DBU_MON;
            next_exc_vector = dbg_event_data ? VEC_DABT : VEC_PABT;
            next_exc_mode   = MODE_ABORT;
          end
        end
      end
      DBU_HALT: begin
        if (core_resume) begin
          next_state = DBU_IDLE;
        end
      end
      default: next_state = DBU_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state      <= DBU_IDLE;
      exc_take   <= 1'b0;
      exc_vector <= VEC_RESET;
      exc_mode   <= MODE_DEBUG;
      cp_rdata   <= 32'h0000_0000;
      cp_undef   <= 1'b0;
    end else begin
      state      <= next_state;
      exc_take   <= next_exc_take;
      exc_vector <= next_exc_vector;
      exc_mode   <= next_exc_mode;
      cp_rdata   <= next_cp_rdata;
      cp_undef   <= next_cp_undef;
    end
  end

  a_user_trap: assert property (@(posedge ref_clk) disable iff (rst)
    (is_dbg && current_mode == MODE_USER) |=> cp_undef)
    else $error("user access did not trap");
  a_dataop_trap: assert property (@(posedge ref_clk) disable iff (rst)
    (is_dbg && cp_dataop) |=> cp_undef)
    else $error("data op did not trap");
  a_halt_vector: assert property (@(posedge ref_clk) disable iff (rst)
    (exc_take && state == DBU_HALT) |-> (exc_vector == VEC_RESET && exc_mode == MODE_DEBUG))
    else $error("halt entry wrong");
  a_mon_mode: assert property (@(posedge ref_clk) disable iff (rst)
    (exc_take && state == DBU_MON) |-> (exc_mode == MODE_ABORT))
    else $error("monitor entry mode wrong");
  a_mon_cause: assert property (@(posedge ref_clk) disable iff (rst)
    (state == DBU_IDLE && accept && !halt_mode && ge && dbg_event_data) |=> exc_vector == VEC_DABT)
    else $error("data cause not data abort");
  a_ge_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (dbg_event && !ge && !reset_trap) |=> !exc_take)
    else $error("disabled event taken");
  a_ge_reset: assert property (@(posedge ref_clk)
    rst |=> !ge)
    else $error("enable set after reset");
  a_sys_write: assert property (@(posedge ref_clk) disable iff (rst)
    (is_sys && priv_ok && cp_write && secondary_index_field == SEC_DBCTL && !jtag_we)
      |=> dbrk_ctrl == $past(cp_wdata))
    else $error("control write lost");
endmodule : dbu_top

// file: bench/dbu_dbg_host.sv
// dbu_dbg_host: behavioural external debugger on the jtag register port.
// assumes the debugger writes on ref_clk with one-cycle strobes.
`timescale 1ns/1ps
module dbu_dbg_host (
  input  wire logic        ref_clk,
  output logic             jtag_we,
  output logic      [2:0]  jtag_sel,
  output logic      [31:0] jtag_wdata
);
  initial begin
    jtag_we    = 1'b0;
    jtag_sel   = 3'h0;
    jtag_wdata = 32'h0000_0000;
  end
  // data lines scrambled once the strobe drops
  task automatic put(input logic [2:0] sel, input logic [31:0] data);
    @(posedge ref_clk);
    jtag_we    <= 1'b1;
    jtag_sel   <= sel;
    jtag_wdata <= data;
    @(posedge ref_clk);
    jtag_we    <= 1'b0;
    jtag_wdata <= ~data;
  endtask : put
endmodule : dbu_dbg_host

// file: bench/test_debug_unit_access_and_modes.sv
// test_debug_unit_access_and_modes: self-checking bench for dbu_top.
// assumes privileged mode 0x13 and the debugger model on the jtag port.
`timescale 1ns/1ps
module test_debug_unit_access_and_modes;
  import dbu_pkg::*;
  localparam logic [4:0] PRIV = 5'h13;
  logic        ref_clk, rst, cp_valid, cp_write, cp_dataop, jtag_we;
  logic        dbg_event, dbg_event_data, reset_trap, core_resume;
  logic        cp_undef, exc_take, core_halted, trace_enable;
  logic [2:0]  jtag_sel;
  logic [3:0]  cp_num, pri, sec;
  logic [4:0]  current_mode, exc_mode;
  logic [31:0] cp_wdata, jtag_wdata, cp_rdata, jtag_rdata, exc_vector;
  logic [31:0] ib0, ib1, db0, db1, dbc;
  int          mismatches, check_count, cycles;

  dbu_top u_dbu_top (.ref_clk(ref_clk), .rst(rst), .cp_valid(cp_valid), .cp_num(cp_num),
    .cp_write(cp_write), .cp_dataop(cp_dataop), .primary_index_field(pri),
    .secondary_index_field(sec), .cp_wdata(cp_wdata), .current_mode(current_mode),
    .jtag_we(jtag_we), .jtag_sel(jtag_sel), .jtag_wdata(jtag_wdata), .dbg_event(dbg_event),
    .dbg_event_data(dbg_event_data), .reset_trap(reset_trap), .core_resume(core_resume),
    .cp_rdata(cp_rdata), .cp_undef(cp_undef), .jtag_rdata(jtag_rdata), .exc_take(exc_take),
    .exc_vector(exc_vector), .exc_mode(exc_mode), .core_halted(core_halted),
    .trace_enable(trace_enable), .ibrk_addr0(ib0), .ibrk_addr1(ib1), .dbrk_addr0(db0),
    .dbrk_addr1(db1), .dbrk_ctrl(dbc));
  dbu_dbg_host u_dbu_dbg_host (.ref_clk(ref_clk), .jtag_we(jtag_we), .jtag_sel(jtag_sel),
    .jtag_wdata(jtag_wdata));

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag
  task automatic cp(input logic [3:0] n, input logic w, input logic op, input logic [3:0] p,
                    input logic [3:0] s, input logic [31:0] d, input logic [4:0] md);
    @(posedge ref_clk);
    cp_valid     <= 1'b1;
    cp_num       <= n;
    cp_write     <= w;
    cp_dataop    <= op;
    pri          <= p;
    sec          <= s;
    cp_wdata     <= d;
    current_mode <= md;
    @(posedge ref_clk);
    cp_valid <= 1'b0;
    #1;
  endtask : cp
  task automatic ev(input logic data_cause);
    @(posedge ref_clk);
    dbg_event      <= 1'b1;
    dbg_event_data <= data_cause;
    @(posedge ref_clk);
    dbg_event <= 1'b0;
    #1;
  endtask : ev
  task automatic resume();
    @(posedge ref_clk);
    core_resume <= 1'b1;
    @(posedge ref_clk);
    core_resume <= 1'b0;
    #1;
    chk_flag("halted after resume", 1'b0, core_halted);
  endtask : resume
  task automatic take(input logic [31:0] vec, input logic [4:0] md, input logic hlt);
    chk_flag("exc_take", 1'b1, exc_take);
    chk_word("exc_vector", vec, exc_vector);
    chk_word("exc_mode", {27'h0, md}, {27'h0, exc_mode});
    chk_flag("core_halted", hlt, core_halted);
  endtask : take

  task automatic t_reset();
    chk_word("exc_mode reset", {27'h0, MODE_DEBUG}, {27'h0, exc_mode});
    chk_flag("trace reset", 1'b0, trace_enable);
  endtask : t_reset
  task automatic t_breaks();
    logic [3:0] s [5] = '{SEC_IBRK0, SEC_IBRK1, SEC_DBRK0, SEC_DBRK1, SEC_DBCTL};
    for (int i = 0; i < 5; i++) begin
      cp(SYS_CP_NUM, 1'b1, 1'b0, SYS_DBG_PRI, s[i], 32'hB0 + i, PRIV);
    end
    chk_word("ibrk_addr0", 32'hB0, ib0);
    chk_word("ibrk_addr1", 32'hB1, ib1);
    chk_word("dbrk_addr0", 32'hB2, db0);
    chk_word("dbrk_addr1", 32'hB3, db1);
    chk_word("dbrk_ctrl", 32'hB4, dbc);
  endtask : t_breaks
  task automatic t_map();
    cp(DBG_CP_NUM, 1'b1, 1'b0, PRI_CHK0, 4'h5, 32'hC0C0_0001, PRIV);
    cp(DBG_CP_NUM, 1'b1, 1'b0, PRI_CHK1, 4'h0, 32'hC1C1_0002, PRIV);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_CHK0, 4'h0, 32'h0, PRIV);
    chk_word("checkpoint0", 32'hC0C0_0001, cp_rdata);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_CHK1, 4'h0, 32'h0, PRIV);
    chk_word("checkpoint1", 32'hC1C1_0002, cp_rdata);
    u_dbu_dbg_host.put(3'h0, 32'h5A5A_0001);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_TX, 4'h0, 32'h0, PRIV);
    chk_word("transmit", 32'h5A5A_0001, cp_rdata);
    chk_word("jtag transmit read", 32'h5A5A_0001, jtag_rdata);
    u_dbu_dbg_host.put(3'h2, 32'hFFFF_FFFF);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_DCS, 4'h0, 32'h0, PRIV);
    chk_word("control via jtag", DCS_JTAG_MASK, cp_rdata);
    chk_word("jtag control read", DCS_JTAG_MASK, jtag_rdata);
    cp(DBG_CP_NUM, 1'b1, 1'b0, PRI_DCS, 4'h0, 32'h0, PRIV);
    u_dbu_dbg_host.put(3'h1, 32'h0BAD_F00D);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_RX, 4'h0, 32'h0, PRIV);
    chk_word("receive", 32'h0BAD_F00D, cp_rdata);
    u_dbu_dbg_host.put(3'h3, 32'h9000_0000);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_HSK, 4'h0, 32'h0, PRIV);
    chk_word("handshake", 32'h9000_0000, cp_rdata);
    chk_word("jtag handshake read", 32'h9000_0000, jtag_rdata);
    cp(DBG_CP_NUM, 1'b1, 1'b0, PRI_TBUF, 4'h0, 32'h7B7B_0003, PRIV);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_TBUF, 4'h0, 32'h0, PRIV);
    chk_word("trace buffer", 32'h7B7B_0003, cp_rdata);
  endtask : t_map
  task automatic t_refuse();
    cp(DBG_CP_NUM, 1'b1, 1'b0, PRI_CHK0, 4'h0, 32'hDEAD_0000, MODE_USER);
    chk_flag("undef user", 1'b1, cp_undef);
    cp(DBG_CP_NUM, 1'b1, 1'b1, PRI_CHK0, 4'h0, 32'hDEAD_0001, PRIV);
    chk_flag("undef dataop", 1'b1, cp_undef);
    cp(DBG_CP_NUM, 1'b0, 1'b0, PRI_CHK0, 4'h0, 32'h0, PRIV);
    chk_flag("undef priv read", 1'b0, cp_undef);
    chk_word("checkpoint0 kept", 32'hC0C0_0001, cp_rdata);
  endtask : t_refuse
  task automatic t_events();
    ev(1'b0);
    chk_flag("event while disabled", 1'b0, exc_take);
    @(posedge ref_clk);
    reset_trap <= 1'b1;
    ev(1'b0);
    take(VEC_RESET, MODE_DEBUG, 1'b1);
    @(posedge ref_clk);
    reset_trap <= 1'b0;
    resume();
    cp(DBG_CP_NUM, 1'b1, 1'b0, PRI_DCS, 4'h0, 32'hC000_0001, PRIV);
    chk_flag("trace on", 1'b1, trace_enable);
    ev(1'b1);
    take(VEC_RESET, MODE_DEBUG, 1'b1);
    // trace enable is cleared on the edge that ends the exception pulse
    @(posedge ref_clk);
    #1;
    chk_flag("trace off", 1'b0, trace_enable);
    ev(1'b1);
    chk_flag("event while halted", 1'b0, exc_take);
    resume();
    cp(DBG_CP_NUM, 1'b1, 1'b0, PRI_DCS, 4'h0, 32'h8000_0000, PRIV);
    ev(1'b1);
    take(VEC_DABT, MODE_ABORT, 1'b0);
    resume();
    ev(1'b0);
    take(VEC_PABT, MODE_ABORT, 1'b0);
  endtask : t_events

  initial begin
    {ref_clk, cp_valid, cp_write, cp_dataop, dbg_event, dbg_event_data} = '0;
    {reset_trap, core_resume, cp_num, pri, sec, cp_wdata} = '0;
    rst = 1'b1;
    current_mode = PRIV;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_breaks();
    t_map();
    t_refuse();
    t_events();
    give_verdict();
  end
endmodule : test_debug_unit_access_and_modes
